/* File: verilog/gpel_pkg.sv */
// Overview of operation
// RULE_01 - Writing one clears status bit and output
// RULE_02 - Status bits set regardless of enable bits
// RULE_03 - Bit 15 sets on video enable change
// RULE_04 - Bit 11 sets on socket power change
// RULE_05 - Bit 8 sets on 12 V request change
// RULE_06 - Bits 4..0 set on input level changes
// RULE_07 - Reserved bits ignore writes, read zero
// RULE_08 - Output holds until status bit cleared
// RULE_09 - Output only when a pin carries it
// RULE_10 - Enable 15 lets video change raise output
// RULE_11 - Enable 11 lets power change raise output
// RULE_12 - Enable 8 lets 12 V change raise output
// RULE_13 - Enables 4..0 raise output if pin configured
// RULE_14 - Output low while status AND enable nonzero
package gpel_pkg;
  localparam int             ADDR_W       = 12;
  localparam int             VCC_W        = 3;
  localparam int             VPP_W        = 3;
  localparam int             GPI_N        = 5;
  localparam logic [7:0]     IDX_STATUS   = 8'ha8;
  localparam logic [7:0]     IDX_ENABLE   = 8'haa;
  localparam logic [11:0]    ADDR_STATUS  = {2'h0, IDX_STATUS, 2'h0};
  localparam logic [11:0]    ADDR_ENABLE  = {2'h0, IDX_ENABLE, 2'h0};
  localparam logic [15:0]    VALID_BITS   = 16'h891f;
  localparam logic [15:0]    STATUS_RESET = 16'h0000;
  localparam logic [15:0]    ENABLE_RESET = 16'h0000;
  localparam int             BIT_VIDEO    = 15;
  localparam int             BIT_POWER    = 11;
  localparam int             BIT_VPP12    = 8;
  localparam logic [2:0]     VPP_12V_CODE = 3'h4;

  typedef struct packed {
    logic [15:0]      status;
    logic [15:0]      enable;
    logic [GPI_N-1:0] prev_gpi;
    logic             prev_video;
    logic [VCC_W-1:0] prev_vcc;
    logic [VPP_W-1:0] prev_vpp;
    logic             primed;
    logic             pready;
    logic             pslverr;
    logic [31:0]      prdata;
    logic             wake_n;
    logic             irq;
  } gpel_state_t;

  localparam gpel_state_t STATE_RESET = '{
    status:     STATUS_RESET,
    enable:     ENABLE_RESET,
    prev_gpi:   5'h00,
    prev_video: 1'h0,
    prev_vcc:   3'h0,
    prev_vpp:   3'h0,
    primed:     1'h0,
    pready:     1'h0,
    pslverr:    1'h0,
    prdata:     32'h0000_0000,
    wake_n:     1'h1,
    irq:        1'h0
  };
endpackage

/* File: verilog/gpel_event_logic.sv */
// Register access over APB was left to the implementer.
`timescale 1ns/1ps
module gpel_event_logic (
  input  wire logic        pclk,                     // Bus clock, 40 MHz
  input  wire logic        presetn,                  // Async reset, low
  input  wire logic        psel,                     // APB select
  input  wire logic        penable,                  // APB enable
  input  wire logic        pwrite,                   // APB direction
  input  wire logic [11:0] paddr,                    // APB byte address
  input  wire logic [31:0] pwdata,                   // APB write data
  input  wire logic [3:0]  pstrb,                    // APB byte strobes
  output logic      [31:0] prdata,                   // APB read data
  output logic             pready,                   // APB ready
  output logic             pslverr,                  // APB error
  input  wire logic        video_port_enable_bit,    // Card control video enable
  input  wire logic [2:0]  socket_vcc_sel,           // Socket supply select
  input  wire logic [2:0]  socket_vpp_sel,           // Programming voltage select
  input  wire logic [4:0]  general_input,            // Pins 5,4,2,1,0 levels
  input  wire logic [4:0]  general_input_cfg,        // Pin is a general input
  input  wire logic        wake_pin_routed,          // A pin carries the wake event
  output logic             system_wake_event_out_n,  // Wake event, low active
  output logic             event_irq                 // Level interrupt, high
);

  gpel_pkg::gpel_state_t st;
  gpel_pkg::gpel_state_t next_st;

  logic [4:0]  gpi_chg;
  logic        video_chg;
  logic        power_chg;
  logic        vpp12_chg;
  logic [15:0] events;
  logic [15:0] wmask;
  logic [15:0] gate;
  logic [15:0] clr;
  logic        xfer_done;
  logic        wr_done;
  logic        wr_status;
  logic        wr_enable;
  logic        mapped;
  logic        active;

  function automatic logic addr_hit(input logic [11:0] addr, input logic [11:0] target);
    addr_hit = (addr == target);
  endfunction

  // Level change detection, suppressed until the first sample after reset
  genvar gi;
  generate
    for (gi = 0; gi < gpel_pkg::GPI_N; gi++) begin : g_gpi
      assign gpi_chg[gi] = st.primed & (general_input[gi] ^ st.prev_gpi[gi]);
    end
  endgenerate

  assign video_chg = st.primed & (video_port_enable_bit ^ st.prev_video);
  assign power_chg = st.primed & ((socket_vcc_sel != st.prev_vcc) | (socket_vpp_sel != st.prev_vpp));
  assign vpp12_chg = st.primed & ((socket_vpp_sel == gpel_pkg::VPP_12V_CODE)
                                  ^ (st.prev_vpp == gpel_pkg::VPP_12V_CODE));

  always_comb begin
    events = 16'h0000;
    events[gpel_pkg::BIT_VIDEO] = video_chg;  // RULE_03
    events[gpel_pkg::BIT_POWER] = power_chg;  // RULE_04
    events[gpel_pkg::BIT_VPP12] = vpp12_chg;  // RULE_05
    events[4:0] = gpi_chg;                    // RULE_06
  end

  assign wmask     = {{8{pstrb[1]}}, {8{pstrb[0]}}};
  assign gate      = {11'h7ff, general_input_cfg};  // RULE_13
  assign xfer_done = psel & penable & st.pready;
  assign wr_done   = xfer_done & pwrite;
  assign wr_status = wr_done & addr_hit(paddr, gpel_pkg::ADDR_STATUS);
  assign wr_enable = wr_done & addr_hit(paddr, gpel_pkg::ADDR_ENABLE);
  assign mapped    = addr_hit(paddr, gpel_pkg::ADDR_STATUS) | addr_hit(paddr, gpel_pkg::ADDR_ENABLE);
  assign clr       = wr_status ? (pwdata[15:0] & wmask & gpel_pkg::VALID_BITS) : 16'h0000;  // RULE_01

  always_comb begin
    next_st = st;
    next_st.primed     = 1'b1;
    next_st.prev_gpi   = general_input;
    next_st.prev_video = video_port_enable_bit;
    next_st.prev_vcc   = socket_vcc_sel;
    next_st.prev_vpp   = socket_vpp_sel;
    // A new event wins over a clear in the same cycle
    next_st.status = ((st.status & ~clr) | events) & gpel_pkg::VALID_BITS;  // RULE_01 RULE_02 RULE_07
    if (wr_enable) begin
      next_st.enable = ((st.enable & ~wmask) | (pwdata[15:0] & wmask)) & gpel_pkg::VALID_BITS;  // RULE_07
    end
    // One wait state: ready rises in the second access cycle
    if (psel & penable & ~st.pready) begin
      next_st.pready  = 1'b1;
      next_st.pslverr = ~mapped;
      if (addr_hit(paddr, gpel_pkg::ADDR_STATUS)) begin
        next_st.prdata = {16'h0000, st.status};
      end else if (addr_hit(paddr, gpel_pkg::ADDR_ENABLE)) begin
        next_st.prdata = {16'h0000, st.enable};
      end else begin
        next_st.prdata = 32'h0000_0000;
      end
    end else if (xfer_done) begin
      next_st.pready  = 1'b0;
      next_st.pslverr = 1'b0;
      next_st.prdata  = 32'h0000_0000;
    end
    active         = |(next_st.status & next_st.enable & gate);  // RULE_10 RULE_11 RULE_12 RULE_13
    next_st.irq    = active;
    next_st.wake_n = ~(wake_pin_routed & active);  // RULE_08 RULE_09 RULE_14
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= gpel_pkg::STATE_RESET;  // RULE_14
    end else begin
      st <= next_st;
    end
  end

  assign prdata                  = st.prdata;
  assign pready                  = st.pready;
  assign pslverr                 = st.pslverr;
  assign system_wake_event_out_n = st.wake_n;
  assign event_irq               = st.irq;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_setup;
    psel && !penable;
  endsequence

  sequence s_wait_then_ready;
    !pready ##1 pready;
  endsequence

  apb_wait_state_a: assert property (s_setup |=> s_wait_then_ready)
    else $error("ready not one wait state after setup");

  w1c_clear_a: assert property (wr_status && pstrb[0] && pwdata[0] && !gpi_chg[0] |=> !st.status[0])  // RULE_01
    else $error("status bit 0 not cleared by write of one");

  zero_keep_a: assert property (wr_status && st.status[15] && !pwdata[15] |=> st.status[15])  // RULE_01
    else $error("write of zero changed status bit 15");

  video_set_a: assert property (video_chg && !st.enable[15] |=> st.status[15])  // RULE_03
    else $error("video change did not set status 15");

  power_set_a: assert property (power_chg |=> st.status[11])  // RULE_04
    else $error("power change did not set status 11");

  vpp12_set_a: assert property (vpp12_chg |=> st.status[8] && st.status[11])  // RULE_05
    else $error("12 V change did not set status 8");

  input_set_a: assert property (gpi_chg[2] && !general_input_cfg[2] |=> st.status[2])  // RULE_06
    else $error("input change did not set status 2");

  event_beats_clear_a: assert property (wr_status && pwdata[4] && pstrb[0] && gpi_chg[4] |=> st.status[4])  // RULE_02
    else $error("event lost against clear");

  reserved_zero_a: assert property (((st.status | st.enable) & ~gpel_pkg::VALID_BITS) == 16'h0000)  // RULE_07
    else $error("reserved bit set");

  wake_hold_a: assert property (!st.wake_n && !wr_done && wake_pin_routed  // RULE_08
                                && $stable(general_input_cfg) |=> !st.wake_n)
    else $error("wake output dropped on its own");

  unrouted_quiet_a: assert property (!wake_pin_routed |=> st.wake_n)  // RULE_09
    else $error("wake output without routed pin");

  video_raise_a: assert property (video_chg && st.enable[15] && wake_pin_routed && !wr_enable  // RULE_10
                                  |=> !st.wake_n && st.irq)
    else $error("video change with enable did not raise wake");

  power_raise_a: assert property (power_chg && st.enable[11] && wake_pin_routed && !wr_enable  // RULE_11
                                  |=> !st.wake_n)
    else $error("power change with enable did not raise wake");

  vpp12_raise_a: assert property (vpp12_chg && st.enable[8] && wake_pin_routed && !wr_enable  // RULE_12
                                  |=> !st.wake_n)
    else $error("12 V change with enable did not raise wake");

  input_gate_a: assert property (st.status == 16'h0001 && st.enable[0] && !general_input_cfg[0]  // RULE_13
                                 && !wr_done && events == 16'h0000 |=> st.wake_n && !st.irq)
    else $error("unconfigured input raised wake");

  wake_level_a: assert property (st.wake_n == !(($past(wake_pin_routed))  // RULE_14
                                 && |(st.status & st.enable & $past(gate))))
    else $error("wake level disagrees with status and enable");

  // Bus side: one wait state, then a single ready cycle
  sequence s_access_wait;
    psel && penable && !pready;
  endsequence

  sequence s_complete;
    psel && penable && pready;
  endsequence

  sequence s_unmapped_wait;
    psel && penable && !pready && !mapped;
  endsequence

  sequence s_mapped_wait;
    psel && penable && !pready && mapped;
  endsequence

  sequence s_status_read;
    psel && penable && !pready && !pwrite && paddr == gpel_pkg::ADDR_STATUS;
  endsequence

  sequence s_enable_read;
    psel && penable && !pready && !pwrite && paddr == gpel_pkg::ADDR_ENABLE;
  endsequence

  sequence s_full_enable_write;
    wr_enable && pstrb[1] && pstrb[0];
  endsequence

  sequence s_low_enable_write;
    wr_enable && pstrb[0] && !pstrb[1];
  endsequence

  sequence s_last_clear;
    wr_status && events == 16'h0000 && ((st.status & ~clr) & st.enable & gate) == 16'h0000;
  endsequence

  ready_released_a: assert property (s_access_wait |=> pready)
    else $error("ready missing after wait state");

  ready_one_cycle_a: assert property (s_complete |=> !pready)
    else $error("ready held past completion");

  err_with_ready_a: assert property (pslverr |-> pready)
    else $error("error flag without ready");

  idle_rdata_zero_a: assert property (!pready |-> prdata == 32'h0000_0000)
    else $error("read data outside ready cycle");

  unmapped_err_a: assert property (s_unmapped_wait |=> pslverr && prdata == 32'h0000_0000)
    else $error("unmapped access not refused");

  mapped_ok_a: assert property (s_mapped_wait |=> !pslverr)
    else $error("mapped access refused");

  status_read_a: assert property (s_status_read |=> prdata == {16'h0000, $past(st.status)})  // RULE_07
    else $error("status read data wrong");

  enable_read_a: assert property (s_enable_read |=> prdata == {16'h0000, $past(st.enable)})  // RULE_07
    else $error("enable read data wrong");

  upper_half_zero_a: assert property (prdata[31:16] == 16'h0000)  // RULE_07
    else $error("upper read data not zero");

  enable_write_a: assert property (s_full_enable_write  // RULE_07
                                   |=> st.enable == ($past(pwdata[15:0]) & gpel_pkg::VALID_BITS))
    else $error("enable write not stored");

  enable_low_byte_a: assert property (s_low_enable_write  // RULE_07
                                      |=> st.enable == {$past(st.enable[15:8]),
                                                        $past(pwdata[7:0]) & gpel_pkg::VALID_BITS[7:0]})
    else $error("byte strobe not honoured on enable");

  enable_hold_a: assert property (!wr_enable |=> st.enable == $past(st.enable))  // RULE_07
    else $error("enable changed without a write");

  status_rise_cause_a: assert property ((st.status & ~$past(st.status) & ~$past(events)) == 16'h0000)  // RULE_02
    else $error("status bit set without an event");

  status_fall_cause_a: assert property ((~st.status & $past(st.status) & ~$past(clr)) == 16'h0000)  // RULE_08
    else $error("status bit fell without a clear");

  status_stable_a: assert property (events == 16'h0000 && clr == 16'h0000  // RULE_08
                                    |=> st.status == $past(st.status))
    else $error("status changed while idle");

  quiet_after_reset_a: assert property (!st.primed |-> events == 16'h0000)
    else $error("event reported before first sample");

  primed_stays_a: assert property (st.primed |=> st.primed)
    else $error("change detector lost its first sample");

  irq_level_a: assert property (st.irq == |(st.status & st.enable & $past(gate)))  // RULE_13 RULE_14
    else $error("interrupt level disagrees with status and enable");

  irq_wake_agree_a: assert property (!st.wake_n |-> st.irq)  // RULE_09
    else $error("wake active without interrupt");

  wake_release_a: assert property (s_last_clear |=> st.wake_n && !st.irq)  // RULE_01
    else $error("clearing the last event left wake active");

  // Per-pin change checks
  generate
    for (gi = 0; gi < gpel_pkg::GPI_N; gi++) begin : g_gpi_chk
      input_bit_set_a: assert property (gpi_chg[gi] |=> st.status[gi])  // RULE_06
        else $error("input change did not set its status bit");
      input_bit_raise_a: assert property (gpi_chg[gi] && st.enable[gi] && general_input_cfg[gi]  // RULE_13
                                          && wake_pin_routed && !wr_enable |=> !st.wake_n)
        else $error("enabled input change did not raise wake");
    end
  endgenerate

  // Per-bit sticky and reserved checks
  genvar bi;
  generate
    for (bi = 0; bi < 16; bi++) begin : g_bit_chk
      if (gpel_pkg::VALID_BITS[bi]) begin : g_valid
        clear_bit_a: assert property (clr[bi] && !events[bi] |=> !st.status[bi])  // RULE_01
          else $error("status bit not cleared by write of one");
        keep_bit_a: assert property (st.status[bi] && !clr[bi] |=> st.status[bi])  // RULE_08
          else $error("status bit dropped without a clear");
      end else begin : g_reserved
        reserved_bit_a: assert property (!st.status[bi] && !st.enable[bi] && !events[bi])  // RULE_07
          else $error("reserved bit became active");
      end
    end
  endgenerate

endmodule

/* File: testbench/gpel_pme_sink.sv */
`timescale 1ns/1ps
module gpel_pme_sink (
  input  wire logic pclk,     // Clock
  input  wire logic presetn,  // Reset, low
  input  wire logic wake_n,   // Wake request, low
  output logic      seen      // Wake seen since reset
);
  // Host side latches any wake request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      seen <= 1'b0;
    else if (!wake_n)
      seen <= 1'b1;
  end
endmodule

/* File: testbench/test_general_purpose_event_logic.sv */
`timescale 1ns/1ps
module test_general_purpose_event_logic;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic        video, wake_n, irq, routed, seen;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  pstrb;
  logic [2:0]  vcc, vpp;
  logic [4:0]  gpi, cfg;
  logic [15:0] e;
  int          errors, checked;

  gpel_event_logic dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .video_port_enable_bit(video), .socket_vcc_sel(vcc), .socket_vpp_sel(vpp), .general_input(gpi),
    .general_input_cfg(cfg), .wake_pin_routed(routed), .system_wake_event_out_n(wake_n), .event_irq(irq));
  gpel_pme_sink host (.pclk(pclk), .presetn(presetn), .wake_n(wake_n), .seen(seen));

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  task automatic tally_and_finish();
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
    checked++;
    if (g !== x) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", n, x, g);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 16; i++) begin
      @(posedge pclk);
      if (pready === 1'b1)
        break;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (i == 16) begin
      errors++;
      tally_and_finish();
    end
  endtask

  // Applies one event source change and sets the expected status bits
  task automatic fire(input int k);
    @(posedge pclk);
    e = (k == 0) ? 16'h8000 : (k == 1 || k == 4) ? 16'h0800 : (k < 4) ? 16'h0900 : 16'h0001 << (k - 5);
    if (k == 0) video <= ~video;
    if (k == 1) vcc <= vcc + 3'h1;
    if (k == 2) vpp <= 3'h4;
    if (k == 3) vpp <= 3'h1;
    if (k == 4) vpp <= 3'h2;
    if (k > 4) gpi[k-5] <= ~gpi[k-5];
    repeat (3) @(posedge pclk);
    #1;
  endtask

  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, video, vcc, vpp, gpi} = '0;
    pstrb = 4'hf;
    cfg = 5'h1f;
    routed = 1'b1;
    errors = 0;
    checked = 0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, gpel_pkg::ADDR_STATUS, 32'h0);
    chk("status", 32'h0, rd);
    apb(1'b0, gpel_pkg::ADDR_ENABLE, 32'h0);
    chk("enable", 32'h0, rd);
    chk("wake_n", 32'h1, {31'h0, wake_n});
    $display("test reset done");
    for (int k = 0; k < 10; k++) begin
      fire(k);
      chk("irq", 32'h0, {31'h0, irq});
      apb(1'b0, gpel_pkg::ADDR_STATUS, 32'h0);
      chk("status", {16'h0, e}, rd);
      apb(1'b1, gpel_pkg::ADDR_STATUS, {16'h0, e});
    end
    $display("test masked events done");
    // Lands an input change on the completing edge of a clearing write
    fork
      apb(1'b1, gpel_pkg::ADDR_STATUS, 32'h10);
      begin
        repeat (3) @(posedge pclk);
        gpi[4] <= ~gpi[4];
      end
    join
    apb(1'b0, gpel_pkg::ADDR_STATUS, 32'h0);
    chk("set_wins", 32'h10, rd);
    apb(1'b1, gpel_pkg::ADDR_STATUS, 32'h10);
    apb(1'b1, gpel_pkg::ADDR_ENABLE, 32'hffff_ffff);
    apb(1'b0, gpel_pkg::ADDR_ENABLE, 32'h0);
    chk("enable", 32'h0000_891f, rd);
    apb(1'b0, 12'h2a4, 32'h0);
    chk("pslverr", 32'h1, {31'h0, err});
    chk("prdata", 32'h0, rd);
    pstrb <= 4'h1;
    apb(1'b1, gpel_pkg::ADDR_ENABLE, 32'h0);
    pstrb <= 4'hf;
    apb(1'b0, gpel_pkg::ADDR_ENABLE, 32'h0);
    chk("enable_low_strobe", 32'h0000_8900, rd);
    apb(1'b1, gpel_pkg::ADDR_ENABLE, 32'hffff_ffff);
    $display("test register map done");
    for (int k = 0; k < 10; k++) begin
      fire(k);
      chk("wake_n", 32'h0, {31'h0, wake_n});
      chk("irq", 32'h1, {31'h0, irq});
      apb(1'b1, gpel_pkg::ADDR_STATUS, {16'h0, ~e});
      repeat (2) @(posedge pclk);
      #1;
      chk("wake_n", 32'h0, {31'h0, wake_n});
      apb(1'b1, gpel_pkg::ADDR_STATUS, {16'h0, e});
      repeat (2) @(posedge pclk);
      #1;
      chk("wake_n", 32'h1, {31'h0, wake_n});
      chk("irq", 32'h0, {31'h0, irq});
    end
    chk("host_seen", 32'h1, {31'h0, seen});
    $display("test enabled events done");
    @(posedge pclk);
    cfg <= 5'h00;
    fire(5);
    chk("irq", 32'h0, {31'h0, irq});
    chk("wake_n", 32'h1, {31'h0, wake_n});
    apb(1'b0, gpel_pkg::ADDR_STATUS, 32'h0);
    chk("status", 32'h1, rd);
    apb(1'b1, gpel_pkg::ADDR_STATUS, 32'h1);
    cfg <= 5'h1f;
    routed <= 1'b0;
    fire(0);
    chk("irq", 32'h1, {31'h0, irq});
    chk("wake_n", 32'h1, {31'h0, wake_n});
    $display("test gating done");
    tally_and_finish();
  end
endmodule
